/* File: verilog/tws_pkg.sv */
`default_nettype none
package tws_pkg;
    localparam int CLK_NS        = 40;
    localparam int SCL_PERIOD_NS = 320;
    localparam int SCL_QTR_RAW   = SCL_PERIOD_NS / (4 * CLK_NS);
    localparam int SCL_QTR_CYC   = (SCL_QTR_RAW < 1) ? 1 : SCL_QTR_RAW;
    // device register port
    localparam int REG_AW = 8;
    localparam logic [7:0] OWN_ADDR_OFS = 8'h20;
    localparam logic [7:0] CTRL_OFS     = 8'h21;
    localparam logic [7:0] STAT_OFS     = 8'h22;
    localparam logic [7:0] DATA_OFS     = 8'h23;
    localparam int CTRL_EN_BIT   = 7;
    localparam int CTRL_TX_BIT   = 4;
    localparam int CTRL_ACK_TO_SEND_BIT = 3;
    localparam int STAT_HCF_BIT  = 7;
    localparam int STAT_ADDRESS_MATCHED_FLAG_BIT = 6;
    localparam int STAT_HBB_BIT  = 5;
    localparam int STAT_SRW_BIT  = 2;
    localparam int STAT_ACK_RECEIVED_BIT = 0;
    localparam int ADDR_LSB      = 1;
    localparam logic [6:0] OWN_ADDR_RST = 7'h00;
    localparam logic [7:0] DATA_RST     = 8'h00;
    localparam logic       ACK_RECEIVED_RST     = 1'h1;
    // host command registers over axi4-lite
    localparam int AXI_AW = 4;
    localparam logic [3:0] CMD_OFS   = 4'h0;
    localparam logic [3:0] HSTAT_OFS = 4'h4;
    localparam int CMD_START_BIT = 0;
    localparam int CMD_STOP_BIT  = 1;
    localparam int CMD_READ_BIT  = 2;
    localparam int CMD_NACK_BIT  = 3;
    localparam int CMD_SKIP_BIT  = 4;
    localparam int CMD_BYTE_LSB  = 8;
    localparam int HST_BUSY_BIT  = 0;
    localparam int HST_NACK_BIT  = 1;
    localparam int HST_RX_LSB    = 8;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [4:0] {
        SLV_IDLE = 5'h01,
        SLV_ADDR = 5'h02,
        SLV_DATA = 5'h04,
        SLV_ACK  = 5'h08,
        SLV_HOLD = 5'h10
    } tws_slv_e;

    typedef enum logic [3:0] {
        MST_IDLE  = 4'h1,
        MST_START = 4'h2,
        MST_BITS  = 4'h4,
        MST_STOP  = 4'h8
    } tws_mst_e;
endpackage
`default_nettype wire

/* File: verilog/tws_if.sv */
`default_nettype none
interface tws_if;
    logic scl;
    logic sda;
    logic scl_dev_o;
    logic scl_dev_oe;
    logic sda_dev_o;
    logic sda_dev_oe;
    logic scl_host_o;
    logic scl_host_oe;
    logic sda_host_o;
    logic sda_host_oe;

    // open-drain wires with pull-ups: low wins
    assign scl = ~((scl_dev_oe & ~scl_dev_o) | (scl_host_oe & ~scl_host_o));
    assign sda = ~((sda_dev_oe & ~sda_dev_o) | (sda_host_oe & ~sda_host_o));

    modport dev  (input scl, input sda, output scl_dev_o, output scl_dev_oe,
                  output sda_dev_o, output sda_dev_oe);
    modport host (input scl, input sda, output scl_host_o,
                  output scl_host_oe, output sda_host_o, output sda_host_oe);
endinterface
`default_nettype wire

/* File: verilog/tws_slave.sv */
`default_nettype none
module tws_slave (
    input  wire logic                       clk_i,
    input  wire logic                       reset_i,
    tws_if.dev                              bus,
    input  wire logic [tws_pkg::REG_AW-1:0] reg_addr_i,
    input  wire logic                       reg_wr_i,
    input  wire logic                       reg_rd_i,
    input  wire logic [7:0]                 reg_wdata_i,
    input  wire logic                       bus_interrupt_enable_i,
    output logic      [7:0]                 reg_rdata_o,
    output logic                            bus_irq_o
);
    import tws_pkg::*;

    typedef struct packed {
        logic [2:0] scl_sy;
        logic [2:0] sda_sy;
        tws_slv_e   st;
        logic [3:0] cnt;
        logic [7:0] sr;
        logic [6:0] own;
        logic       en;
        logic       tx;
        logic       ack_to_send;
        logic       byte_complete_flag;
        logic       address_matched_flag;
        logic       bus_busy_flag;
        logic       direction_flag;
        logic       ack_received;
        logic       ackv;
        logic       ackrx;
        logic [7:0] data;
        logic       scl_oe;
        logic       sda_oe;
        logic [7:0] rdata;
        logic       irq;
        logic       svc;
    } tws_slv_s;

    tws_slv_s q;
    tws_slv_s n;

    logic       scl_h;
    logic       scl_rise;
    logic       scl_fall;
    logic       sda_in;
    logic       start_c;
    logic       stop_c;
    logic       wr_data;
    logic       acc;
    logic [7:0] tx_byte;
    logic [7:0] stat;
    logic [7:0] ctrl;

    // [0] is the first synchroniser flop, [2] only keeps history
    assign scl_h    = q.scl_sy[1];
    assign scl_rise = q.scl_sy[1] & ~q.scl_sy[2];
    assign scl_fall = ~q.scl_sy[1] & q.scl_sy[2];
    assign sda_in   = q.sda_sy[1];
    assign start_c  = scl_h & q.scl_sy[2] & ~q.sda_sy[1] & q.sda_sy[2];
    assign stop_c   = scl_h & q.scl_sy[2] & q.sda_sy[1] & ~q.sda_sy[2];
    assign wr_data  = reg_wr_i & (reg_addr_i == DATA_OFS);
    assign acc      = (reg_wr_i | reg_rd_i) & (reg_addr_i == DATA_OFS);
    // a write in the releasing cycle is the byte that goes out
    assign tx_byte  = wr_data ? reg_wdata_i : q.data;

    always_comb begin
        stat = 8'h00;
        ctrl = 8'h00;
        stat[STAT_HCF_BIT]  = q.byte_complete_flag;
        stat[STAT_ADDRESS_MATCHED_FLAG_BIT] = q.address_matched_flag;
        stat[STAT_HBB_BIT]  = q.bus_busy_flag;
        stat[STAT_SRW_BIT]  = q.direction_flag;
        stat[STAT_ACK_RECEIVED_BIT] = q.ack_received;
        ctrl[CTRL_EN_BIT]   = q.en;
        ctrl[CTRL_TX_BIT]   = q.tx;
        ctrl[CTRL_ACK_TO_SEND_BIT] = q.ack_to_send;
    end

    always_comb begin
        n = q;
        n.irq = 1'h0;
        n.scl_sy = {q.scl_sy[1:0], bus.scl};
        n.sda_sy = {q.sda_sy[1:0], bus.sda};

        if (reg_rd_i) begin
            case (reg_addr_i)
                OWN_ADDR_OFS: n.rdata = {q.own, 1'h0};
                CTRL_OFS:     n.rdata = ctrl;
                STAT_OFS:     n.rdata = stat;
                DATA_OFS:     n.rdata = q.data;
                default:      n.rdata = 8'h00;
            endcase
        end
        if (reg_wr_i) begin
            case (reg_addr_i)
                OWN_ADDR_OFS: n.own = reg_wdata_i[7:ADDR_LSB];
                CTRL_OFS: begin
                    n.en   = reg_wdata_i[CTRL_EN_BIT];
                    n.tx   = reg_wdata_i[CTRL_TX_BIT];
                    n.ack_to_send = reg_wdata_i[CTRL_ACK_TO_SEND_BIT];
                    n.address_matched_flag = 1'h0;
                end
                DATA_OFS: n.data = reg_wdata_i;
                default: ;
            endcase
        end

        // busy tracking follows the wire even when not addressed
        if (start_c) begin
            n.bus_busy_flag = 1'h1;
        end else if (stop_c) begin
            n.bus_busy_flag = 1'h0;
        end

        if (!q.en) begin
            n.st     = SLV_IDLE;
            n.scl_oe = 1'h0;
            n.sda_oe = 1'h0;
            n.svc    = 1'h0;
        end else if (start_c) begin
            n.st     = SLV_ADDR;
            n.cnt    = 4'h0;
            n.byte_complete_flag    = 1'h0;
            n.scl_oe = 1'h0;
            n.sda_oe = 1'h0;
            n.svc    = 1'h0;
        end else if (stop_c) begin
            n.st     = SLV_IDLE;
            n.scl_oe = 1'h0;
            n.sda_oe = 1'h0;
            n.svc    = 1'h0;
        end else begin
            case (q.st)
                SLV_IDLE: ;
                SLV_ADDR: begin
                    if (scl_rise) begin
                        n.sr  = {q.sr[6:0], sda_in};
                        n.cnt = q.cnt + 4'h1;
                        if (q.cnt == 4'h7) begin
                            if (q.sr[6:0] == q.own) begin
                                n.direction_flag   = sda_in;
                                n.address_matched_flag  = 1'h1;
                                n.byte_complete_flag   = 1'h1;
                                n.irq   = bus_interrupt_enable_i;
                                n.ackv  = 1'h0;
                                n.ackrx = 1'h0;
                                n.st    = SLV_ACK;
                            end else begin
                                n.address_matched_flag = 1'h0;
                                n.st   = SLV_IDLE;
                            end
                        end
                    end
                end
                SLV_ACK: begin
                    // software may answer the flag before the hold
                    // begins; losing that access would lock the bus
                    if (acc) begin
                        n.svc = 1'h1;
                    end
                    if (scl_fall && q.cnt == 4'h8) begin
                        n.cnt = 4'h9;
                        // ninth clock: drive ack or let master answer
                        n.sda_oe = q.ackrx ? 1'h0 : ~q.ackv;
                    end else if (scl_rise && q.cnt == 4'h9) begin
                        if (q.ackrx) begin
                            n.ack_received = sda_in;
                        end
                    end else if (scl_fall && q.cnt == 4'h9) begin
                        n.sda_oe = 1'h0;
                        n.scl_oe = 1'h1;
                        n.st     = SLV_HOLD;
                    end
                end
                SLV_HOLD: begin
                    // clock stays low until software touches the data
                    if (acc || q.svc) begin
                        n.svc    = 1'h0;
                        n.scl_oe = 1'h0;
                        n.byte_complete_flag    = 1'h0;
                        n.cnt    = 4'h0;
                        n.st     = SLV_DATA;
                        if (q.tx) begin
                            n.sr     = tx_byte;
                            n.sda_oe = ~tx_byte[7];
                        end else begin
                            n.sda_oe = 1'h0;
                        end
                    end
                end
                SLV_DATA: begin
                    if (scl_rise) begin
                        n.cnt = q.cnt + 4'h1;
                        if (!q.tx) begin
                            n.sr = {q.sr[6:0], sda_in};
                        end
                        if (q.cnt == 4'h7) begin
                            n.byte_complete_flag   = 1'h1;
                            n.irq   = bus_interrupt_enable_i;
                            n.ackrx = q.tx;
                            n.ackv  = q.ack_to_send;
                            n.st    = SLV_ACK;
                            if (!q.tx) begin
                                n.data = {q.sr[6:0], sda_in};
                            end
                        end
                    end else if (scl_fall && q.tx) begin
                        n.sr     = {q.sr[6:0], 1'h0};
                        n.sda_oe = ~q.sr[6];
                    end
                end
                default: begin
                    n.st     = SLV_IDLE;
                    n.scl_oe = 1'h0;
                    n.sda_oe = 1'h0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            q        <= '0;
            q.scl_sy <= 3'h7;
            q.sda_sy <= 3'h7;
            q.st     <= SLV_IDLE;
            q.own    <= OWN_ADDR_RST;
            q.data   <= DATA_RST;
            q.ack_received   <= ACK_RECEIVED_RST;
        end else begin
            q <= n;
        end
    end

    assign bus.scl_dev_o  = 1'h0;
    assign bus.sda_dev_o  = 1'h0;
    assign bus.scl_dev_oe = q.scl_oe;
    assign bus.sda_dev_oe = q.sda_oe;
    assign reg_rdata_o    = q.rdata;
    assign bus_irq_o      = q.irq;
endmodule // tws_slave
`default_nettype wire

/* File: verilog/tws_master.sv */
`default_nettype none
module tws_master (
    input  wire logic                       clk_i,
    input  wire logic                       reset_i,
    tws_if.host                             bus,
    input  wire logic [tws_pkg::AXI_AW-1:0] s_axi_awaddr_i,
    input  wire logic                       s_axi_awvalid_i,
    output logic                            s_axi_awready_o,
    input  wire logic [31:0]                s_axi_wdata_i,
    input  wire logic [3:0]                 s_axi_wstrb_i,
    input  wire logic                       s_axi_wvalid_i,
    output logic                            s_axi_wready_o,
    output logic      [1:0]                 s_axi_bresp_o,
    output logic                            s_axi_bvalid_o,
    input  wire logic                       s_axi_bready_i,
    input  wire logic [tws_pkg::AXI_AW-1:0] s_axi_araddr_i,
    input  wire logic                       s_axi_arvalid_i,
    output logic                            s_axi_arready_o,
    output logic      [31:0]                s_axi_rdata_o,
    output logic      [1:0]                 s_axi_rresp_o,
    output logic                            s_axi_rvalid_o,
    input  wire logic                       s_axi_rready_i
);
    import tws_pkg::*;

    typedef struct packed {
        logic [1:0]  scl_sy;
        logic [1:0]  sda_sy;
        tws_mst_e    st;
        logic [1:0]  ph;
        logic [7:0]  tick;
        logic [3:0]  bitn;
        logic [8:0]  sh;
        logic        stop_p;
        logic        rd;
        logic        nackc;
        logic        skip;
        logic [7:0]  rx;
        logic        nack;
        logic        scl_oe;
        logic        sda_oe;
        logic        awready;
        logic        wready;
        logic        aw_got;
        logic        w_got;
        logic [3:0]  aw_addr;
        logic [31:0] wdata;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } tws_mst_s;

    localparam logic [7:0] QTR_LAST = 8'(SCL_QTR_CYC - 1);

    tws_mst_s q;
    tws_mst_s n;
    logic     tk;
    logic     scl_h;
    logic     sda_in;

    assign tk     = (q.tick == QTR_LAST);
    assign scl_h  = q.scl_sy[1];
    assign sda_in = q.sda_sy[1];

    always_comb begin
        n = q;
        n.scl_sy = {q.scl_sy[0], bus.scl};
        n.sda_sy = {q.sda_sy[0], bus.sda};
        n.tick   = tk ? 8'h00 : q.tick + 8'h01;

        // axi4-lite: address and data accepted in either order
        if (s_axi_awvalid_i && q.awready) begin
            n.aw_got  = 1'h1;
            n.aw_addr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && q.wready) begin
            n.w_got = 1'h1;
            n.wdata = s_axi_wdata_i;
        end
        if (q.bvalid && s_axi_bready_i) begin
            n.bvalid = 1'h0;
        end
        if (q.aw_got && q.w_got && !q.bvalid) begin
            n.aw_got = 1'h0;
            n.w_got  = 1'h0;
            n.bvalid = 1'h1;
            n.bresp  = RESP_SLVERR;
            // commands while busy are refused, not queued
            if (q.aw_addr == CMD_OFS && q.st == MST_IDLE) begin
                n.bresp  = RESP_OKAY;
                n.stop_p = q.wdata[CMD_STOP_BIT];
                n.rd     = q.wdata[CMD_READ_BIT];
                n.nackc  = q.wdata[CMD_NACK_BIT];
                n.skip   = q.wdata[CMD_SKIP_BIT];
                n.sh     = {q.wdata[CMD_BYTE_LSB +: 8], 1'h1};
                n.bitn   = 4'h0;
                n.ph     = 2'h0;
                n.st     = q.wdata[CMD_START_BIT] ? MST_START
                         : (q.wdata[CMD_SKIP_BIT] ? MST_STOP : MST_BITS);
            end
        end
        n.awready = ~n.aw_got & ~n.bvalid;
        n.wready  = ~n.w_got & ~n.bvalid;

        if (q.rvalid && s_axi_rready_i) begin
            n.rvalid = 1'h0;
        end
        if (s_axi_arvalid_i && q.arready) begin
            n.rvalid = 1'h1;
            n.rresp  = RESP_OKAY;
            n.rdata  = 32'h0000_0000;
            if (s_axi_araddr_i == HSTAT_OFS) begin
                n.rdata[HST_BUSY_BIT]           = (q.st != MST_IDLE);
                n.rdata[HST_NACK_BIT]           = q.nack;
                n.rdata[HST_RX_LSB +: 8]        = q.rx;
            end else if (s_axi_araddr_i != CMD_OFS) begin
                n.rresp = RESP_SLVERR;
            end
        end
        n.arready = ~n.rvalid;

        // each bit is four quarter periods; phase 2 waits for a
        // stretched clock to come back high
        if (tk && !(q.ph == 2'h2 && !scl_h)) begin
            n.ph = q.ph + 2'h1;
            case (q.st)
                MST_IDLE: n.ph = 2'h0;
                MST_START: begin
                    case (q.ph)
                        2'h0: n.sda_oe = 1'h0;
                        2'h1: n.scl_oe = 1'h0;
                        2'h2: n.sda_oe = 1'h1;
                        default: begin
                            n.scl_oe = 1'h1;
                            // address byte follows the start, or the stop when skip is set
                            n.st = q.skip ? MST_STOP : MST_BITS;
                        end
                    endcase
                end
                MST_BITS: begin
                    case (q.ph)
                        2'h0: begin
                            if (q.bitn == 4'h8) begin
                                n.sda_oe = q.rd & ~q.nackc;
                            end else begin
                                n.sda_oe = ~q.rd & ~q.sh[8];
                            end
                        end
                        2'h1: n.scl_oe = 1'h0;
                        2'h2: n.sh = {q.sh[7:0], sda_in};
                        default: begin
                            n.scl_oe = 1'h1;
                            n.bitn   = q.bitn + 4'h1;
                            if (q.bitn == 4'h8) begin
                                n.sda_oe = 1'h0;
                                n.rx     = q.sh[8:1];
                                n.nack   = ~q.rd & q.sh[0];
                                if ((~q.rd & q.sh[0]) || q.stop_p) begin
                                    n.st = MST_STOP;
                                end else begin
                                    n.st = MST_IDLE;
                                end
                            end
                        end
                    endcase
                end
                MST_STOP: begin
                    case (q.ph)
                        2'h0: n.sda_oe = 1'h1;
                        2'h1: n.scl_oe = 1'h0;
                        2'h2: n.sda_oe = 1'h0;
                        default: n.st = MST_IDLE;
                    endcase
                end
                default: n.st = MST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            q        <= '0;
            q.scl_sy <= 2'h3;
            q.sda_sy <= 2'h3;
            q.st     <= MST_IDLE;
        end else begin
            q <= n;
        end
    end

    assign bus.scl_host_o  = 1'h0;
    assign bus.sda_host_o  = 1'h0;
    assign bus.scl_host_oe = q.scl_oe;
    assign bus.sda_host_oe = q.sda_oe;
    assign s_axi_awready_o = q.awready;
    assign s_axi_wready_o  = q.wready;
    assign s_axi_bresp_o   = q.bresp;
    assign s_axi_bvalid_o  = q.bvalid;
    assign s_axi_arready_o = q.arready;
    assign s_axi_rdata_o   = q.rdata;
    assign s_axi_rresp_o   = q.rresp;
    assign s_axi_rvalid_o  = q.rvalid;
endmodule // tws_master
`default_nettype wire

/* File: verification/tws_properties.sv */
`default_nettype none
module tws_properties (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic scl,
    input wire logic sda,
    input wire logic scl_dev_oe,
    input wire logic sda_dev_oe,
    input wire logic sda_host_oe
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    sequence s_start; $fell(sda) && scl && $past(scl); endsequence
    sequence s_stop; $rose(sda) && scl && $past(scl); endsequence
    property p_start_host; s_start |-> sda_host_oe; endproperty
    a_start_host: assert property (p_start_host)
        else $error("start not made by host");
    property p_stop_host; s_stop |-> $past(sda_host_oe) && !sda_dev_oe;
    endproperty
    a_stop_host: assert property (p_stop_host)
        else $error("stop not made by host");
    property p_start_quiet; s_start |=> !sda_dev_oe [*4]; endproperty
    a_start_quiet: assert property (p_start_quiet)
        else $error("device drives data during address");
    property p_dev_sda_low; $changed(sda_dev_oe) |-> !scl; endproperty
    a_dev_sda_low: assert property (p_dev_sda_low)
        else $error("device data moved while clock high");
    property p_ack_hold; $rose(scl) |-> $stable(sda_dev_oe) [*3]; endproperty
    a_ack_hold: assert property (p_ack_hold)
        else $error("device data not held over clock high");
    property p_hold_low; $rose(scl_dev_oe) |-> !scl; endproperty
    a_hold_low: assert property (p_hold_low)
        else $error("clock hold began with clock high");
    property p_release; $fell(scl_dev_oe) |-> ##[1:12] scl; endproperty
    a_release: assert property (p_release)
        else $error("clock not resumed after release");
    property p_no_clash; scl && $past(scl) |-> !(sda_dev_oe && sda_host_oe);
    endproperty
    a_no_clash: assert property (p_no_clash)
        else $error("both ends drive data");
    property p_host_sda;
        $changed(sda_host_oe) && scl && $past(scl) |-> s_start or s_stop;
    endproperty
    a_host_sda: assert property (p_host_sda)
        else $error("host data moved while clock high");
endmodule // tws_properties
`default_nettype wire

/* File: verification/i2c_slave_interface_bench.sv */
`default_nettype none
module i2c_slave_interface_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import tws_pkg::*;
    logic        clk_i = 0, reset_i = 1, rd = 0, wr = 0, ie = 0;
    logic        awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [7:0]  raddr = 0, rwd = 0, rrd, s, own;
    logic [3:0]  araddr = 0;
    logic [1:0]  bresp, rresp;
    logic [31:0] wdata = 0, rdata, h, seed = 32'h5b063f59;
    logic [7:0]  q[$];
    int          err_total = 0, n_tests = 0, irq_n = 0;
    tws_if bus_if ();
    tws_slave tws_slave_i (.clk_i(clk_i), .reset_i(reset_i), .bus(bus_if),
        .reg_addr_i(raddr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(rwd),
        .bus_interrupt_enable_i(ie), .reg_rdata_o(rrd), .bus_irq_o(irq));
    tws_master tws_master_i (.clk_i(clk_i), .reset_i(reset_i), .bus(bus_if),
        .s_axi_awaddr_i(CMD_OFS), .s_axi_awvalid_i(awv),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
        .s_axi_arvalid_i(arv), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));
    tws_properties tws_properties_i (.clk_i(clk_i), .reset_i(reset_i),
        .scl(bus_if.scl), .sda(bus_if.sda), .scl_dev_oe(bus_if.scl_dev_oe),
        .sda_dev_oe(bus_if.sda_dev_oe), .sda_host_oe(bus_if.sda_host_oe));
    initial forever #20 clk_i = ~clk_i;
    always @(posedge clk_i) if (irq === 1'b1) irq_n++;
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic rw(input logic [7:0] a, d);
        raddr <= a;
        rwd <= d;
        wr <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rr(input logic [7:0] a, output logic [7:0] d);
        raddr <= a;
        rd <= 1'b1;
        @(posedge clk_i);
        rd <= 1'b0;
        @(posedge clk_i);
        d = rrd;
    endtask
    // reads just after the edge still see the values sampled at it
    task automatic axw(input logic [31:0] d);
        logic ta, tw;
        ta = 0;
        tw = 0;
        hidle();
        wdata <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk_i);
            ta |= awv & awready;
            tw |= wv & wready;
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
        end while (!(ta && tw));
        while (!bvalid) @(posedge clk_i);
        chk("bresp", RESP_OKAY, bresp);
        bready <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic hidle();
        do begin
            araddr <= HSTAT_OFS;
            arv <= 1'b1;
            rready <= 1'b1;
            do @(posedge clk_i); while (!arready);
            arv <= 1'b0;
            while (!rvalid) @(posedge clk_i);
            h = rdata;
            chk("rresp", RESP_OKAY, rresp);
            rready <= 1'b0;
            @(posedge clk_i);
        end while (h[HST_BUSY_BIT] !== 1'b0);
    endtask
    task automatic sdone();
        do rr(STAT_OFS, s); while (s[STAT_HCF_BIT] !== 1'b1);
    endtask
    initial begin
        #2400000;
        err_total++;
        conclude();
    end
    initial begin
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rr(STAT_OFS, s);
        chk("status reset", 8'h01, s);
        rr(CTRL_OFS, s);
        chk("ctrl reset", 8'h00, s);
        rr(8'h24, s);
        chk("unmapped", 8'h00, s);
        h = xs();
        own = {h[6:0], 1'b0};
        rw(OWN_ADDR_OFS, own);
        rw(CTRL_OFS, 8'h80);
        ie <= 1'b1;
        rr(OWN_ADDR_OFS, s);
        chk("own addr", own, s);
        for (int k = 0; k < 2; k++) begin
            axw({16'h0, own, 8'h01});
            sdone();
            chk("addr status", 8'he1, s);
            rw(CTRL_OFS, {4'h8, k[0], 3'h0});
            rr(STAT_OFS, s);
            chk("matched clear", 8'h00, s & 8'h40);
            rr(DATA_OFS, s);
            h = xs();
            q.push_back(h[7:0]);
            axw({16'h0, h[7:0], 8'h02});
            sdone();
            rr(DATA_OFS, s);
            chk("rx byte", q.pop_front(), s);
            hidle();
            chk("host nack", k, h[HST_NACK_BIT]);
            rr(STAT_OFS, s);
            chk("busy clear", 8'h00, s & 8'h20);
            $display("test write %0d done", k);
        end
        axw({16'h0, own | 8'h01, 8'h01});
        sdone();
        chk("direction", 8'h04, s & 8'h04);
        rw(CTRL_OFS, 8'h90);
        for (int k = 0; k < 2; k++) begin
            h = xs();
            q.push_back(h[7:0]);
            rw(DATA_OFS, h[7:0]);
            axw({28'h0, k[0], 1'b1, k[0], 1'b0});
            sdone();
            // the ninth clock lands some cycles after the byte flag
            repeat (16) @(posedge clk_i);
            rr(STAT_OFS, s);
            chk("ack received", k, s[STAT_ACK_RECEIVED_BIT]);
            if (k == 1) begin
                rw(CTRL_OFS, 8'h80);
                rr(DATA_OFS, s);
            end
            hidle();
            chk("tx byte", q.pop_front(), h[15:8]);
        end
        $display("test read done");
        axw({16'h0, own ^ 8'h02, 8'h03});
        hidle();
        chk("miss nack", 1, h[HST_NACK_BIT]);
        rr(STAT_OFS, s);
        chk("miss status", 8'h00, s & 8'h60);
        chk("irq count", 7, irq_n);
        $display("test mismatch done");
        conclude();
    end
endmodule // i2c_slave_interface_bench
`default_nettype wire
